// file: src/ssla_top.sv
// Serial line assist: open-drain clock/data lines with edge logic
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "ssla_defines.svh"

module ssla_top (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    // Avalon-MM slave
    input  wire logic [7:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output      logic [31:0]            avs_readdata,
    output      logic                   avs_waitrequest,
    // Port logic drive of the two bits when the block is off
    input  wire ssla_pkg::ssla_pin_drv_s port_clock_drv,
    input  wire ssla_pkg::ssla_pin_drv_s port_data_drv,
    // Clock pin
    input  wire logic                   clock_pin_in,
    output      logic                   clock_pin_out,
    output      logic                   clock_pin_oe,
    // Data pin
    input  wire logic                   data_pin_in,
    output      logic                   data_pin_out,
    output      logic                   data_pin_oe,
    // Condition interrupt requests
    output      logic                   condition_one_irq,
    output      logic                   condition_two_irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ssla_pkg::ssla_state_s state_reg;
    ssla_pkg::ssla_state_s state_next;

    // ------------------------------------------------------------
    // Decoded events from the bus inputs and the previous state
    // ------------------------------------------------------------
    logic        req;
    logic        accept;
    logic        wr_acc;
    logic        rd_acc;
    logic        clk_rise;
    logic        clk_fall;
    logic        dat_rise;
    logic        dat_fall;
    logic        hit_data;
    logic        hit_clock;
    logic        hit_ctl;
    logic        hit_c1;
    logic        hit_c2;
    logic        hit_smp;
    logic        hit_rise;
    logic        low_lane;
    logic        cond_one_evt;
    logic        cond_two_evt;
    logic        stretch_evt;
    logic [31:0] rd_mux;

    // Effects land on the edge that sees waitrequest low, the one
    // edge at which the master is sure to still hold its request
    always_comb begin
        req    = avs_read | avs_write;
        accept = req && (state_reg.bus == ssla_pkg::SSLA_BUS_ACK);
        wr_acc = accept && avs_write;
        rd_acc = accept && avs_read && !avs_write;
        low_lane = avs_byteenable[0];
    end

    // Address decode; unmapped addresses read zero, writes dropped
    always_comb begin
        hit_data  = (avs_address == `SSLA_OFF_DATA_LINE);
        hit_clock = (avs_address == `SSLA_OFF_CLOCK_LINE);
        hit_ctl   = (avs_address == `SSLA_OFF_CONTROL);
        hit_c1    = (avs_address == `SSLA_OFF_COND_ONE);
        hit_c2    = (avs_address == `SSLA_OFF_COND_TWO);
        hit_smp   = (avs_address == `SSLA_OFF_SAMPLED);
        hit_rise  = (avs_address == `SSLA_OFF_CLOCK_RISE);
    end

    // Edges seen only on synchronised samples, never the meta stage
    always_comb begin
        clk_rise = state_reg.clk_in.sync & ~state_reg.clk_in.prev;
        clk_fall = ~state_reg.clk_in.sync & state_reg.clk_in.prev;
        dat_rise = state_reg.dat_in.sync & ~state_reg.dat_in.prev;
        dat_fall = ~state_reg.dat_in.sync & state_reg.dat_in.prev;
    end

    // Line conditions, qualified by the block enable
    always_comb begin
        cond_one_evt = state_reg.block_enable
                     & dat_fall & state_reg.clk_in.sync;
        cond_two_evt = state_reg.block_enable
                     & dat_rise & state_reg.clk_in.sync;
        // Conditional stretch looks at the flag as it stood before
        // this fall, so a condition on the same cycle does not count
        stretch_evt  = state_reg.block_enable & clk_fall
                     & (state_reg.stretch_enable
                     | (state_reg.cond_stretch_enable
                        & state_reg.condition_one_flag));
    end

    // Read data mux; pin registers show the pad, not the stored bit
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_data) begin
            rd_mux[0] = state_reg.dat_in.sync;
        end
        if (hit_clock) begin
            rd_mux[0] = state_reg.clk_in.sync;
        end
        if (hit_ctl) begin
            rd_mux[`SSLA_CTL_ENABLE_BIT]  = state_reg.block_enable;
            rd_mux[`SSLA_CTL_STRETCH_BIT] = state_reg.stretch_enable;
            rd_mux[`SSLA_CTL_COND_BIT]    = state_reg.cond_stretch_enable;
            rd_mux[`SSLA_CTL_ACTIVE_BIT]  =
                state_reg.stretch_active_flag;
        end
        if (hit_c1) begin
            rd_mux[0] = state_reg.condition_one_flag;
        end
        if (hit_c2) begin
            rd_mux[0] = state_reg.condition_two_flag;
        end
        if (hit_smp) begin
            rd_mux[0] = state_reg.sampled_data_bit;
        end
        if (hit_rise) begin
            rd_mux[0] = state_reg.clock_rise_flag;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // Bus handshake: one wait cycle, then a single ack cycle
        case (state_reg.bus)
            ssla_pkg::SSLA_BUS_IDLE: begin
                if (req) begin
                    state_next.bus     = ssla_pkg::SSLA_BUS_ACK;
                    state_next.waitreq = 1'b0;
                    state_next.readdata =
                        avs_read ? rd_mux : 32'h0000_0000;
                end
            end
            ssla_pkg::SSLA_BUS_ACK: begin
                state_next.bus     = ssla_pkg::SSLA_BUS_IDLE;
                state_next.waitreq = 1'b1;
            end
            default: begin
                state_next.bus     = ssla_pkg::SSLA_BUS_IDLE;
                state_next.waitreq = 1'b1;
            end
        endcase

        // Two-flop synchronisers with one stage of edge history
        state_next.clk_in.meta = clock_pin_in;
        state_next.clk_in.sync = state_reg.clk_in.meta;
        state_next.clk_in.prev = state_reg.clk_in.sync;
        state_next.dat_in.meta = data_pin_in;
        state_next.dat_in.sync = state_reg.dat_in.meta;
        state_next.dat_in.prev = state_reg.dat_in.sync;

        // Software writes to drive and control bits
        if (wr_acc && low_lane) begin
            if (hit_data) begin
                state_next.data_line_drive = avs_writedata[0];
            end
            if (hit_clock) begin
                state_next.clock_line_drive = avs_writedata[0];
            end
            if (hit_ctl) begin
                state_next.block_enable =
                    avs_writedata[`SSLA_CTL_ENABLE_BIT];
                state_next.stretch_enable =
                    avs_writedata[`SSLA_CTL_STRETCH_BIT];
                state_next.cond_stretch_enable =
                    avs_writedata[`SSLA_CTL_COND_BIT];
            end
        end

        // Condition flags: any write clears, a new detection wins
        if (wr_acc && hit_c1) begin
            state_next.condition_one_flag = 1'b0;
        end
        if (cond_one_evt) begin
            state_next.condition_one_flag = 1'b1;
        end
        if (wr_acc && hit_c2) begin
            state_next.condition_two_flag = 1'b0;
        end
        if (cond_two_evt) begin
            state_next.condition_two_flag = 1'b1;
        end

        // One pulse per detection, even if the flag is already set
        state_next.condition_one_irq = cond_one_evt;
        state_next.condition_two_irq = cond_two_evt;

        // Stretch: release by any write to the sampled register
        if (wr_acc && hit_smp) begin
            state_next.stretch_active_flag = 1'b0;
        end
        if (stretch_evt) begin
            state_next.stretch_active_flag = 1'b1;
        end
        if (!state_reg.block_enable) begin
            // Nothing may hold the line once the block lets go
            state_next.stretch_active_flag = 1'b0;
        end

        // Sample on clock rise; the read that clears loses to a rise
        if (rd_acc && hit_smp) begin
            state_next.clock_rise_flag = 1'b0;
        end
        if (state_reg.block_enable && clk_rise) begin
            state_next.sampled_data_bit =
                state_reg.dat_in.sync;
            state_next.clock_rise_flag = 1'b1;
        end

        // Pin drive: open drain while enabled, port logic otherwise
        if (state_reg.block_enable) begin
            state_next.clock_pin.out = 1'b0;
            state_next.clock_pin.oe  = ~state_next.clock_line_drive
                | state_next.stretch_active_flag;
            state_next.data_pin.out  = 1'b0;
            state_next.data_pin.oe   =
                ~state_next.data_line_drive;
        end else begin
            state_next.clock_pin = port_clock_drv;
            state_next.data_pin  = port_data_drv;
        end

        // Synchronous reset; every flop takes a constant
        if (rst) begin
            state_next.bus                 = ssla_pkg::SSLA_BUS_IDLE;
            state_next.waitreq             = 1'b1;
            state_next.readdata            = 32'h0000_0000;
            state_next.clk_in              = 3'h7; // Idle high, no false edge
            state_next.dat_in              = 3'h7; // Idle high, no false edge
            state_next.data_line_drive     = `SSLA_DRIVE_RST;
            state_next.clock_line_drive    = `SSLA_DRIVE_RST;
            state_next.block_enable        = `SSLA_CTL_RST;
            state_next.stretch_enable      = `SSLA_CTL_RST;
            state_next.cond_stretch_enable = `SSLA_CTL_RST;
            state_next.stretch_active_flag = `SSLA_FLAG_RST;
            state_next.condition_one_flag  = `SSLA_FLAG_RST;
            state_next.condition_two_flag  = `SSLA_FLAG_RST;
            state_next.sampled_data_bit    = `SSLA_SAMPLE_RST;
            state_next.clock_rise_flag     = `SSLA_FLAG_RST;
            state_next.condition_one_irq   = 1'b0;
            state_next.condition_two_irq   = 1'b0;
            state_next.clock_pin           = 2'h0;
            state_next.data_pin            = 2'h0;
        end
    end

    // Single register for the whole state
    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    // ------------------------------------------------------------
    // Outputs, each straight from a flop
    // ------------------------------------------------------------
    always_comb begin
        avs_readdata      = state_reg.readdata;
        avs_waitrequest   = state_reg.waitreq;
        clock_pin_out     = state_reg.clock_pin.out;
        clock_pin_oe      = state_reg.clock_pin.oe;
        data_pin_out      = state_reg.data_pin.out;
        data_pin_oe       = state_reg.data_pin.oe;
        condition_one_irq = state_reg.condition_one_irq;
        condition_two_irq = state_reg.condition_two_irq;
    end

endmodule : ssla_top

// file: src/ssla_defines.svh
// Register offsets, field positions and reset values of the line assist
`ifndef SSLA_DEFINES_SVH
`define SSLA_DEFINES_SVH


// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SSLA_OFF_DATA_LINE   8'h00
`define SSLA_OFF_CLOCK_LINE  8'h04
`define SSLA_OFF_CONTROL     8'h08
`define SSLA_OFF_COND_ONE    8'h0C
`define SSLA_OFF_COND_TWO    8'h10
`define SSLA_OFF_SAMPLED     8'h14
`define SSLA_OFF_CLOCK_RISE  8'h18

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define SSLA_CTL_ENABLE_BIT   0
`define SSLA_CTL_STRETCH_BIT  1
`define SSLA_CTL_COND_BIT     2
`define SSLA_CTL_ACTIVE_BIT   3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SSLA_DRIVE_RST   1'b1
`define SSLA_CTL_RST     1'b0
`define SSLA_FLAG_RST    1'b0
`define SSLA_SAMPLE_RST  1'b0

`endif

// file: src/ssla_pkg.sv
// Types shared by the serial line assist
package ssla_pkg;

    // Bus handshake states, one-hot
    typedef enum logic [1:0] {
        SSLA_BUS_IDLE = 2'b01,
        SSLA_BUS_ACK  = 2'b10
    } ssla_bus_e;

    // Drive of one pin: level and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } ssla_pin_drv_s;

    // Two-stage synchroniser plus edge history of one pin
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } ssla_sync_s;

    // Whole state of the line assist
    typedef struct packed {
        ssla_bus_e     bus;
        logic          waitreq;
        logic [31:0]   readdata;
        ssla_sync_s    clk_in;
        ssla_sync_s    dat_in;
        logic          data_line_drive;
        logic          clock_line_drive;
        logic          block_enable;
        logic          stretch_enable;
        logic          cond_stretch_enable;
        logic          stretch_active_flag;
        logic          condition_one_flag;
        logic          condition_two_flag;
        logic          sampled_data_bit;
        logic          clock_rise_flag;
        logic          condition_one_irq;
        logic          condition_two_irq;
        ssla_pin_drv_s clock_pin;
        ssla_pin_drv_s data_pin;
    } ssla_state_s;

endpackage : ssla_pkg

// file: dv/ssla_peer.sv
// Peer model on the shared open-drain clock and data lines
`timescale 1ns/10ps

module ssla_peer (
    input  wire logic clk_low,
    input  wire logic dat_low,
    input  wire logic clock_pin_out,
    input  wire logic clock_pin_oe,
    input  wire logic data_pin_out,
    input  wire logic data_pin_oe,
    output      logic clock_level,
    output      logic data_level
);
    // Pull-ups fitted: a line nobody pulls low reads high
    assign clock_level = !((clock_pin_oe && !clock_pin_out)
                           || clk_low);
    assign data_level  = !((data_pin_oe && !data_pin_out)
                           || dat_low);
endmodule : ssla_peer

// file: dv/ssla_checker.sv
// Concurrent checks on the serial line assist ports
`timescale 1ns/10ps

module ssla_checker (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        clock_pin_in,
    input wire logic        clock_pin_out,
    input wire logic        clock_pin_oe,
    input wire logic        data_pin_in,
    input wire logic        data_pin_out,
    input wire logic        data_pin_oe,
    input wire logic        condition_one_irq,
    input wire logic        condition_two_irq
);
    logic [2:0] ctl_q;
    logic [1:0] en_h;
    logic       cdrv_q;
    logic       ddrv_q;
    logic       c1_q;
    logic       wr_ack;
    logic       rd_ack;
    logic       en_ok;
    assign wr_ack = avs_write && !avs_waitrequest;
    assign rd_ack = avs_read && !avs_waitrequest;
    // Enable must settle two cycles before pin checks apply
    assign en_ok  = ctl_q[0] && (en_h == 2'b11);

    // Shadow of stored settings from completed writes, and of condition one from its request
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctl_q  <= 3'h0;
            en_h   <= 2'h0;
            cdrv_q <= 1'b1;
            ddrv_q <= 1'b1;
            c1_q   <= 1'b0;
        end else begin
            en_h <= {en_h[0], ctl_q[0]};
            if (wr_ack && avs_address == 8'h08) ctl_q <= avs_writedata[2:0];
            if (wr_ack && avs_address == 8'h04) cdrv_q <= avs_writedata[0];
            if (wr_ack && avs_address == 8'h00) ddrv_q <= avs_writedata[0];
            if (condition_one_irq) c1_q <= 1'b1;
            else if (wr_ack && avs_address == 8'h0C) c1_q <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_open_drain;
        en_ok |-> !clock_pin_out && !data_pin_out;
    endproperty
    property p_follow;
        en_ok && ctl_q[2:1] == 2'b00 |->
            clock_pin_oe == !cdrv_q && data_pin_oe == !ddrv_q;
    endproperty
    property p_cond_one;
        en_ok && clock_pin_in && $fell(data_pin_in)
            |-> ##[1:6] condition_one_irq;
    endproperty
    property p_cond_two;
        en_ok && clock_pin_in && $rose(data_pin_in)
            |-> ##[1:6] condition_two_irq;
    endproperty
    property p_irq_pulse;
        condition_one_irq || condition_two_irq |=>
            !condition_one_irq && !condition_two_irq;
    endproperty
    property p_stretch;
        en_ok && ctl_q[1] && $fell(clock_pin_in) |-> ##[1:6] clock_pin_oe;
    endproperty
    property p_cond_stretch;
        en_ok && ctl_q == 3'h5 && c1_q && $fell(clock_pin_in)
            |-> ##[1:6] clock_pin_oe;
    endproperty
    property p_no_stretch;
        en_ok && ctl_q == 3'h5 && cdrv_q && !c1_q && !condition_one_irq
            && $fell(clock_pin_in) |-> ##1 (!clock_pin_oe) [*6];
    endproperty
    property p_release;
        wr_ack && avs_address == 8'h14 && cdrv_q |-> ##[1:2] !clock_pin_oe;
    endproperty
    property p_ctl_read;
        rd_ack && avs_address == 8'h08 |->
            avs_readdata[2:0] == ctl_q && avs_readdata[31:4] == 28'h0;
    endproperty
    property p_flag_read;
        rd_ack && avs_address == 8'h0C |-> avs_readdata == {31'h0, c1_q};
    endproperty

    a_open_drain: assert property (p_open_drain)
        else $error("pin driven high while enabled");
    a_follow: assert property (p_follow)
        else $error("pin enable differs from stored drive");
    a_cond_one: assert property (p_cond_one)
        else $error("condition one not raised");
    a_cond_two: assert property (p_cond_two)
        else $error("condition two not raised");
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("condition request longer than one cycle");
    a_stretch: assert property (p_stretch)
        else $error("clock not held after fall");
    a_cond_stretch: assert property (p_cond_stretch)
        else $error("clock not held with condition one set");
    a_no_stretch: assert property (p_no_stretch)
        else $error("clock held without condition one");
    a_release: assert property (p_release)
        else $error("clock not released by sample write");
    a_ctl_read: assert property (p_ctl_read)
        else $error("control readback wrong");
    a_flag_read: assert property (p_flag_read)
        else $error("condition one readback wrong");

    c_stretch: cover property (ctl_q[1] && clock_pin_oe && !clock_pin_in);
    c_cond_one: cover property (condition_one_irq);
    c_release: cover property (wr_ack && avs_address == 8'h14);
endmodule : ssla_checker

bind ssla_top ssla_checker u_chk (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .clock_pin_in(clock_pin_in),
    .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe),
    .data_pin_in(data_pin_in), .data_pin_out(data_pin_out),
    .data_pin_oe(data_pin_oe), .condition_one_irq(condition_one_irq),
    .condition_two_irq(condition_two_irq)
);

// file: dv/ssla_top_tb.sv
// Self-checking bench of the serial line assist
`timescale 1ns/10ps

module ssla_top_tb;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        clk_low = 1'b0;
    logic        dat_low = 1'b0;
    // Port logic drives both bits high; must not reach enabled pins
    ssla_pkg::ssla_pin_drv_s port_drv = 2'b11;
    logic        clock_pin_in, clock_pin_out, clock_pin_oe;
    logic        data_pin_in, data_pin_out, data_pin_oe;
    logic [7:0]  rd;
    int          err_total = 0;
    int          cmp_count = 0;
    int          cyc_count = 0;
    // Reset table: address in the upper byte, expected value below
    logic [15:0] rows [8] = '{16'h0001, 16'h0401, 16'h0800, 16'h0C00,
                              16'h1000, 16'h1400, 16'h1800, 16'h1C00};

    ssla_top dut (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_clock_drv(port_drv), .port_data_drv(port_drv),
        .clock_pin_in(clock_pin_in), .clock_pin_out(clock_pin_out),
        .clock_pin_oe(clock_pin_oe), .data_pin_in(data_pin_in),
        .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
        .condition_one_irq(), .condition_two_irq());
    ssla_peer peer (
        .clk_low(clk_low), .dat_low(dat_low),
        .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe),
        .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
        .clock_level(clock_pin_in), .data_level(data_pin_in));

    // ----------------------------------------------------------------
    // Clock, timeout and tasks
    // ----------------------------------------------------------------
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // Guard against a slave that never answers
    always @(posedge sys_clk) begin
        cyc_count++;
        if (cyc_count == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    // One Avalon cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= !w;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // Lets pad changes pass the synchroniser before reading
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        cyc(4);
        bus(1'b0, a, 8'h00);
        cmp_count++;
        if (rd !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, rd, exp);
            err_total++;
        end
    endtask : rdchk
    // Half a link period is 6 cycles, so the link runs at 48 ns
    task automatic line(input logic c, input logic d);
        @(posedge sys_clk);
        clk_low <= c;
        dat_low <= d;
        cyc(5);
    endtask : line

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        cyc(20);
        rst <= 1'b0;
        foreach (rows[i]) rdchk(rows[i][15:8], rows[i][7:0]);
        $display("reset table done");
        // Own drive of the data line makes both conditions
        bus(1'b1, 8'h08, 8'h01);
        bus(1'b1, 8'h00, 8'h00);
        rdchk(8'h00, 8'h00);
        rdchk(8'h0C, 8'h01);
        bus(1'b1, 8'h00, 8'h01);
        rdchk(8'h10, 8'h01);
        bus(1'b1, 8'h0C, 8'hA5);
        rdchk(8'h0C, 8'h00);
        bus(1'b1, 8'h10, 8'h00);
        rdchk(8'h10, 8'h00);
        // Peer overrides a released line
        line(1'b0, 1'b1);
        rdchk(8'h00, 8'h00);
        line(1'b0, 1'b0);
        bus(1'b1, 8'h04, 8'h00);
        rdchk(8'h04, 8'h00);
        bus(1'b1, 8'h04, 8'h01);
        $display("line drive done");
        // Two link bits, data moved only while the clock is low
        line(1'b1, 1'b0);
        line(1'b1, 1'b1);
        line(1'b0, 1'b1);
        rdchk(8'h18, 8'h01);
        rdchk(8'h14, 8'h00);
        rdchk(8'h18, 8'h00);
        line(1'b1, 1'b1);
        line(1'b1, 1'b0);
        line(1'b0, 1'b0);
        rdchk(8'h14, 8'h01);
        $display("sampling done");
        // Unconditional stretch, then release by sample write
        bus(1'b1, 8'h08, 8'h03);
        line(1'b1, 1'b0);
        line(1'b0, 1'b0);
        rdchk(8'h04, 8'h00);
        rdchk(8'h08, 8'h0B);
        bus(1'b1, 8'h14, 8'h5A);
        rdchk(8'h08, 8'h03);
        rdchk(8'h04, 8'h01);
        // Conditional stretch: none before condition one, then held
        bus(1'b1, 8'h08, 8'h05);
        bus(1'b1, 8'h0C, 8'h00);
        line(1'b1, 1'b0);
        line(1'b0, 1'b0);
        rdchk(8'h08, 8'h05);
        line(1'b0, 1'b1);
        line(1'b1, 1'b1);
        line(1'b0, 1'b1);
        rdchk(8'h08, 8'h0D);
        bus(1'b1, 8'h14, 8'h00);
        rdchk(8'h08, 8'h05);
        line(1'b0, 1'b0);
        $display("stretch done");
        // Disabled block ignores conditions
        bus(1'b1, 8'h08, 8'h00);
        bus(1'b1, 8'h0C, 8'h00);
        bus(1'b1, 8'h10, 8'h00);
        line(1'b0, 1'b1);
        line(1'b0, 1'b0);
        rdchk(8'h0C, 8'h00);
        rdchk(8'h10, 8'h00);
        // Disabled pins follow the port logic, here pulling both low
        port_drv <= 2'b01;
        rdchk(8'h04, 8'h00);
        rdchk(8'h00, 8'h00);
        port_drv <= 2'b11;
        // Reset in mid-run clears the control bits
        bus(1'b1, 8'h08, 8'h07);
        @(posedge sys_clk);
        rst <= 1'b1;
        cyc(4);
        rst <= 1'b0;
        rdchk(8'h08, 8'h00);
        rdchk(8'h00, 8'h01);
        // Stored drive bits reset to 1, so enabled lines stay released
        bus(1'b1, 8'h08, 8'h01);
        rdchk(8'h00, 8'h01);
        rdchk(8'h04, 8'h01);
        $display("disable and reset done");
        end_sim();
    end
endmodule : ssla_top_tb
